// File: rtl/ppac_defines.svh
// Purpose: Named constants of the power path and alert block
// Assumes: Included by bare name
// Notes:   Command codes and pin slots are local choices
`ifndef PPAC_DEFINES_SVH
`define PPAC_DEFINES_SVH
// ----------------------------------------
// Commands
// ----------------------------------------
`define PPAC_CMD_SRC_DEFAULT 8'h01
`define PPAC_CMD_SRC_HIGH    8'h02
`define PPAC_CMD_SRC_OFF     8'h03
`define PPAC_CMD_SINK_ON     8'h04
`define PPAC_CMD_SINK_OFF    8'h05
`define PPAC_CMD_DET_ON      8'h06
`define PPAC_CMD_DET_OFF     8'h07
// ----------------------------------------
// Levels and fields
// ----------------------------------------
`define PPAC_SAFE0_LEVEL     10'h010
`define PPAC_ZERO_LEVEL      10'h000
`define PPAC_LINE_OPEN       2'h0
`define PPAC_ALERT_CONN      0
`define PPAC_ALERT_POWER     1
`define PPAC_ALERT_FAULT     2
`define PPAC_ALERT_VENDOR    3
`define PPAC_ALERT_MASK_INIT 4'h7
`define PPAC_VENDOR_MASK_INIT 2'h0
`define PPAC_FAULT_OCP       0
`define PPAC_FAULT_CCSHORT   1
// ----------------------------------------
// Pin slots
// ----------------------------------------
`define PPAC_PIN_CC1_HIGH    0
`define PPAC_PIN_CC2_HIGH    1
`define PPAC_PIN_PRESENT     2
`define PPAC_PIN_OCP         3
`define PPAC_PIN_HOT         4
`define PPAC_PIN_VCONN_LOW   5
`define PPAC_PIN_PARTNER_RD  6
// ----------------------------------------
// Timing
// ----------------------------------------
`define PPAC_QUICK_SWAP_NS   90000
`define PPAC_LINK_PERIOD_PS  15000
`endif

// File: rtl/ppac_pkg.sv
// Purpose: Types of the power path and alert block
// Assumes: Nothing
// Notes:   One-hot state codes
package ppac_pkg;
  typedef enum logic [1:0] {
    ppac_dis_idle   = 2'b01,
    ppac_dis_active = 2'b10
  } ppac_dis_state_t;
  typedef enum logic [2:0] {
    ppac_vc_open   = 3'b001,
    ppac_vc_closed = 3'b010,
    ppac_vc_bleed  = 3'b100
  } ppac_vc_state_t;
endpackage : ppac_pkg

// File: rtl/ppac_power_alert.sv
// Purpose: VBUS/VCONN supervision, alerts and swap pulse
// Assumes: Register logic drives the control ports
// Notes:   Analog pins pass two flops; quick swap on link clock
// What this block does
// - Accept VBUS source and sink commands, ignore them
// - Store VBUS reading only while measuring enabled
// - Forced discharge bit starts internal VBUS discharge
// - Bleed-off bit blocks every internal VBUS discharge
// - High CC under Rd: flag, lines open
// - Source auto discharge when partner drops Rd
// - Forced source discharge stops at stop level if auto discharge on
// - Hard Reset never starts automatic VBUS discharge
// - Sink discharge on present fall, zero threshold
// - Sink discharge on crossing nonzero threshold
// - VCONN opens at reset, enable closes selected line
// - Six events open a closed VCONN switch
// - Opening applies Rd until safe, then Rp
// - Cable bleed-off bit skips VCONN discharge
// - Unmasked events pull interrupt low; write-one clears
// - Vendor events masked at reset, need both masks
// - Swap bit emits one pulse, then self-clears
// - Unattached: VCONN, PHY off; attach raises alert
// - Active mode gates PHY enable
`include "ppac_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ppac_power_alert #(
  parameter int VW                = 10,
  parameter int QUICK_SWAP_CYCLES =
    (`PPAC_QUICK_SWAP_NS * 1000 + `PPAC_LINK_PERIOD_PS - 1) / `PPAC_LINK_PERIOD_PS
) (
  // Clocks and reset
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          link_clock,
  // Analog pins
  input  wire logic          cc1_over_limit,
  input  wire logic          cc2_over_limit,
  input  wire logic          vbus_present_pin,
  input  wire logic          vconn_overcurrent,
  input  wire logic          over_temp,
  input  wire logic          vconn_at_safe0,
  input  wire logic          partner_rd_present,
  // Same-clock status
  input  wire logic [VW-1:0] vbus_sample,
  input  wire logic [1:0]    raw_line1_state,
  input  wire logic [1:0]    raw_line2_state,
  input  wire logic          rd_presented,
  input  wire logic          attached,
  input  wire logic          debounce_done,
  input  wire logic          receiver_detect_set,
  input  wire logic          hard_reset_rx,
  input  wire logic [1:0]    vendor_event,
  // Control bits
  input  wire logic          command_strobe,
  input  wire logic [7:0]    command_code,
  input  wire logic          measure_enable,
  input  wire logic          force_discharge,
  input  wire logic          auto_discharge,
  input  wire logic          power_role,
  input  wire logic          internal_bus_bleed_off,
  input  wire logic          internal_cable_bleed_off,
  input  wire logic          vconn_enable,
  input  wire logic          flip_select,
  input  wire logic          role_requests_rp,
  input  wire logic          otsd_enable,
  input  wire logic [VW-1:0] sink_threshold,
  input  wire logic [VW-1:0] stop_level,
  input  wire logic [3:0]    alert_mask,
  input  wire logic [1:0]    vendor_mask,
  input  wire logic [3:0]    alert_clear,
  input  wire logic [1:0]    fault_clear,
  input  wire logic [1:0]    vendor_clear,
  input  wire logic          quick_swap_write,
  // Status
  output logic [VW-1:0]      vbus_voltage,
  output logic [1:0]         line1_termination_state,
  output logic [1:0]         line2_termination_state,
  output logic               presence_detect_on,
  output logic [3:0]         alert_flags,
  output logic [1:0]         fault_flags,
  output logic [1:0]         vendor_flags,
  output logic               quick_swap_busy,
  output logic               active_mode,
  output logic               phy_enable,
  // Power path
  output logic               bus_bleed_on,
  output logic               vconn_to_line1,
  output logic               vconn_to_line2,
  output logic               vconn_bleed_rd,
  output logic               present_rp,
  output logic               interrupt_n,
  // Link side
  output logic               quick_swap_pulse
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin;
  assign pin_raw = {partner_rd_present, vconn_at_safe0, over_temp,
                    vconn_overcurrent, vbus_present_pin,
                    cc2_over_limit, cc1_over_limit};
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          pin_meta[i] <= 1'b0;
          pin[i]      <= 1'b0;
        end else begin
          pin_meta[i] <= pin_raw[i];
          pin[i]      <= pin_meta[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  logic prev_present;
  logic prev_partner;
  logic prev_force;
  logic prev_vconn_en;
  logic prev_attached;
  logic prev_above;
  wire  above_thr = vbus_voltage >= sink_threshold;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_present  <= 1'b0;
      prev_partner  <= 1'b0;
      prev_force    <= 1'b0;
      prev_vconn_en <= 1'b0;
      prev_attached <= 1'b0;
      prev_above    <= 1'b0;
    end else begin
      prev_present  <= pin[`PPAC_PIN_PRESENT];
      prev_partner  <= pin[`PPAC_PIN_PARTNER_RD];
      prev_force    <= force_discharge;
      prev_vconn_en <= vconn_enable;
      prev_attached <= attached;
      prev_above    <= above_thr;
    end
  end

  // ----------------------------------------
  // Commands and measurement
  // ----------------------------------------
  // Source and sink VBUS codes fall through: switching is external
  wire det_on  = command_strobe && command_code == `PPAC_CMD_DET_ON;
  wire det_off = command_strobe && command_code == `PPAC_CMD_DET_OFF;
  wire vbus_cmd = command_strobe &&
                  (command_code == `PPAC_CMD_SRC_DEFAULT ||
                   command_code == `PPAC_CMD_SRC_HIGH ||
                   command_code == `PPAC_CMD_SRC_OFF ||
                   command_code == `PPAC_CMD_SINK_ON ||
                   command_code == `PPAC_CMD_SINK_OFF);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      presence_detect_on <= 1'b0;
      vbus_voltage       <= `PPAC_ZERO_LEVEL;
    end else begin
      if (det_on)
        presence_detect_on <= 1'b1;
      else if (det_off)
        presence_detect_on <= 1'b0;
      if (measure_enable)
        vbus_voltage <= vbus_sample;
    end
  end

  // ----------------------------------------
  // VBUS discharge
  // ----------------------------------------
  ppac_pkg::ppac_dis_state_t dis_state;
  ppac_pkg::ppac_dis_state_t next_dis_state;
  logic dis_forced;
  wire  force_rise  = force_discharge && !prev_force;
  wire  partner_gone = prev_partner && !pin[`PPAC_PIN_PARTNER_RD];
  wire  src_disc    = power_role && auto_discharge && partner_gone;
  wire  sink_drop   = !power_role && auto_discharge && presence_detect_on
                      && sink_threshold == `PPAC_ZERO_LEVEL
                      && prev_present && !pin[`PPAC_PIN_PRESENT];
  wire  sink_cross  = !power_role && auto_discharge
                      && sink_threshold != `PPAC_ZERO_LEVEL
                      && prev_above && !above_thr;
  // Hard Reset is deliberately absent from the automatic causes
  wire  auto_start  = src_disc || sink_drop || sink_cross;
  wire  use_stop    = dis_forced && power_role && auto_discharge
                      && stop_level > `PPAC_SAFE0_LEVEL;
  wire  dis_done    = use_stop ? vbus_sample <= stop_level
                               : vbus_sample <= `PPAC_SAFE0_LEVEL;
  always_comb begin
    next_dis_state = dis_state;
    unique case (dis_state)
      ppac_pkg::ppac_dis_idle:
        if (force_rise || auto_start)
          next_dis_state = ppac_pkg::ppac_dis_active;
      ppac_pkg::ppac_dis_active:
        if (dis_done || (dis_forced && !force_discharge))
          next_dis_state = ppac_pkg::ppac_dis_idle;
      default: next_dis_state = ppac_pkg::ppac_dis_idle;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dis_state  <= ppac_pkg::ppac_dis_idle;
      dis_forced <= 1'b0;
    end else begin
      dis_state  <= next_dis_state;
      if (dis_state == ppac_pkg::ppac_dis_idle)
        dis_forced <= force_rise;
    end
  end
  // State still runs when blocked, so an external bleeder can follow it
  assign bus_bleed_on = dis_state == ppac_pkg::ppac_dis_active
                        && !internal_bus_bleed_off;

  // ----------------------------------------
  // CC short and line states
  // ----------------------------------------
  wire cc_short = rd_presented && (pin[`PPAC_PIN_CC1_HIGH] ||
                                   pin[`PPAC_PIN_CC2_HIGH]);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      line1_termination_state <= `PPAC_LINE_OPEN;
      line2_termination_state <= `PPAC_LINE_OPEN;
    end else begin
      line1_termination_state <= cc_short ? `PPAC_LINE_OPEN
                                          : raw_line1_state;
      line2_termination_state <= cc_short ? `PPAC_LINE_OPEN
                                          : raw_line2_state;
    end
  end

  // ----------------------------------------
  // VCONN switch
  // ----------------------------------------
  ppac_pkg::ppac_vc_state_t vc_state;
  ppac_pkg::ppac_vc_state_t next_vc_state;
  wire vc_close = vconn_enable && !prev_vconn_en && attached;
  wire ocp_hit  = vc_state == ppac_pkg::ppac_vc_closed && pin[`PPAC_PIN_OCP];
  wire vc_open_ev = !vconn_enable || pin[`PPAC_PIN_OCP]
                    || (otsd_enable && pin[`PPAC_PIN_HOT])
                    || hard_reset_rx || partner_gone
                    || !attached;
  always_comb begin
    next_vc_state = vc_state;
    unique case (vc_state)
      ppac_pkg::ppac_vc_open:
        if (vc_close)
          next_vc_state = ppac_pkg::ppac_vc_closed;
      ppac_pkg::ppac_vc_closed:
        if (vc_open_ev)
          next_vc_state = internal_cable_bleed_off
                          ? ppac_pkg::ppac_vc_open
                          : ppac_pkg::ppac_vc_bleed;
      ppac_pkg::ppac_vc_bleed:
        if (pin[`PPAC_PIN_VCONN_LOW])
          next_vc_state = ppac_pkg::ppac_vc_open;
      default: next_vc_state = ppac_pkg::ppac_vc_open;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      vc_state <= ppac_pkg::ppac_vc_open;
    else
      vc_state <= next_vc_state;
  end
  assign vconn_to_line1 = vc_state == ppac_pkg::ppac_vc_closed && !flip_select;
  assign vconn_to_line2 = vc_state == ppac_pkg::ppac_vc_closed && flip_select;
  assign vconn_bleed_rd = vc_state == ppac_pkg::ppac_vc_bleed;
  assign present_rp     = role_requests_rp && !vconn_bleed_rd;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  assign active_mode = (line1_termination_state != `PPAC_LINE_OPEN ||
                        line2_termination_state != `PPAC_LINE_OPEN)
                       && debounce_done && auto_discharge;
  assign phy_enable  = active_mode && attached
                       && receiver_detect_set;

  // ----------------------------------------
  // Alerts and faults
  // ----------------------------------------
  // Every flag: set wins over a same-cycle clear
  logic [3:0] alert_mask_q;
  logic [1:0] vendor_mask_q;
  wire  [1:0] fault_set = {cc_short, ocp_hit};
  wire        conn_ev   = attached && !prev_attached;
  wire        power_ev  = prev_present != pin[`PPAC_PIN_PRESENT];
  wire        vendor_sum = |(vendor_flags & vendor_mask_q);
  wire  [3:0] alert_set = {vendor_sum, |fault_flags, power_ev, conn_ev};
  wire  [3:0] next_alert = (alert_flags & ~alert_clear) | alert_set;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      alert_flags   <= 4'h0;
      fault_flags   <= 2'h0;
      vendor_flags  <= 2'h0;
      alert_mask_q  <= `PPAC_ALERT_MASK_INIT;
      vendor_mask_q <= `PPAC_VENDOR_MASK_INIT;
      interrupt_n   <= 1'b1;
    end else begin
      alert_mask_q  <= alert_mask;
      vendor_mask_q <= vendor_mask;
      // Fault alert stays set while any fault field is set
      alert_flags   <= next_alert;
      fault_flags   <= (fault_flags & ~fault_clear) | fault_set;
      vendor_flags  <= (vendor_flags & ~vendor_clear) | vendor_event;
      interrupt_n   <= ~|(next_alert & alert_mask_q);
    end
  end

  // ----------------------------------------
  // Quick swap, system side
  // ----------------------------------------
  logic req_toggle;
  logic done_meta;
  logic done_sync;
  logic done_seen;
  logic done_toggle;
  wire  swap_done = done_sync != done_seen;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_toggle      <= 1'b0;
      quick_swap_busy <= 1'b0;
      done_meta       <= 1'b0;
      done_sync       <= 1'b0;
      done_seen       <= 1'b0;
    end else begin
      done_meta <= done_toggle;
      done_sync <= done_meta;
      done_seen <= done_sync;
      if (quick_swap_write && !quick_swap_busy) begin
        req_toggle      <= ~req_toggle;
        quick_swap_busy <= 1'b1;
      end else if (swap_done) begin
        quick_swap_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Quick swap, link side
  // ----------------------------------------
  localparam int CW = $clog2(QUICK_SWAP_CYCLES + 1);
  localparam logic [CW-1:0] SWAP_LAST = CW'(QUICK_SWAP_CYCLES - 1);
  logic          req_meta;
  logic          req_sync;
  logic          req_seen;
  logic [CW-1:0] swap_count;
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      req_meta         <= 1'b0;
      req_sync         <= 1'b0;
      req_seen         <= 1'b0;
      swap_count       <= '0;
      quick_swap_pulse <= 1'b0;
      done_toggle      <= 1'b0;
    end else begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
      if (!quick_swap_pulse && req_sync != req_seen) begin
        req_seen         <= req_sync;
        quick_swap_pulse <= 1'b1;
        swap_count       <= '0;
      end else if (quick_swap_pulse) begin
        if (swap_count == SWAP_LAST) begin
          quick_swap_pulse <= 1'b0;
          done_toggle      <= ~done_toggle;
        end else begin
          swap_count <= swap_count + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_cmd_ignored: assert property (vbus_cmd |=> $stable(presence_detect_on))
    else $error("vbus command changed detection");
  a_measure_hold: assert property (!measure_enable |=> $stable(vbus_voltage))
    else $error("vbus reading moved while disabled");
  a_force_starts: assert property (dis_state == ppac_pkg::ppac_dis_idle
      && force_rise |=> dis_state == ppac_pkg::ppac_dis_active)
    else $error("forced discharge did not start");
  a_bleed_blocked: assert property (internal_bus_bleed_off |-> !bus_bleed_on)
    else $error("internal discharge ran while disabled");
  a_short_open: assert property (cc_short |=> line1_termination_state ==
      `PPAC_LINE_OPEN && line2_termination_state == `PPAC_LINE_OPEN && fault_flags[1])
    else $error("cc short not reported");
  a_src_discharge: assert property (dis_state == ppac_pkg::ppac_dis_idle
      && src_disc |=> dis_state == ppac_pkg::ppac_dis_active)
    else $error("source disconnect discharge missing");
  a_hard_reset_quiet: assert property (dis_state == ppac_pkg::ppac_dis_idle
      && hard_reset_rx && !auto_start && !force_rise
      |=> dis_state == ppac_pkg::ppac_dis_idle)
    else $error("hard reset started discharge");
  a_sink_drop: assert property (dis_state == ppac_pkg::ppac_dis_idle
      && sink_drop |=> dis_state == ppac_pkg::ppac_dis_active)
    else $error("sink present drop discharge missing");
  a_vconn_opens: assert property (vc_state == ppac_pkg::ppac_vc_closed
      && vc_open_ev |=> !vconn_to_line1 && !vconn_to_line2)
    else $error("vconn switch stayed closed");
  a_vconn_bleeds: assert property (vc_state == ppac_pkg::ppac_vc_closed
      && vc_open_ev && !internal_cable_bleed_off |=> vconn_bleed_rd && !present_rp)
    else $error("vconn discharge not applied");
  a_vendor_masked: assert property ($past(vendor_mask_q) == 2'h0
      |-> !alert_flags[`PPAC_ALERT_VENDOR] || $past(alert_flags[`PPAC_ALERT_VENDOR]))
    else $error("masked vendor event raised alert");
  a_swap_accept: assert property (quick_swap_write && !quick_swap_busy
      |=> quick_swap_busy ##1 quick_swap_busy)
    else $error("swap bit not held during pulse");
endmodule : ppac_power_alert
`default_nettype wire

// File: bench/ppac_plant.sv
// Purpose: Supply plant model on the far side of the power path block
// Assumes: Bleed controls come from the block under test
// Notes:   VBUS drops one unit a cycle while bled; no real analog timing
`timescale 1ns/1ps
`default_nettype none
module ppac_plant (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Block side
  input  wire logic       bus_bleed_on,
  input  wire logic       vconn_bleed_rd,
  // Bench side
  input  wire logic       load,
  input  wire logic [9:0] load_level,
  // Levels seen by the block
  output logic      [9:0] vbus_sample,
  output logic            vconn_at_safe0
);
  logic [2:0] bleed_count;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      vbus_sample <= 10'h000;
      bleed_count <= 3'h0;
    end else begin
      if (load) begin
        vbus_sample <= load_level;
      end else if (bus_bleed_on && vbus_sample != 10'h000) begin
        vbus_sample <= vbus_sample - 10'h001;
      end
      if (!vconn_bleed_rd) begin
        bleed_count <= 3'h0;
      end else if (bleed_count != 3'h4) begin
        bleed_count <= bleed_count + 3'h1;
      end
    end
  end
  // Slow bleed so the block must really wait for the safe level
  assign vconn_at_safe0 = (bleed_count == 3'h4);
endmodule : ppac_plant
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the power path and alert block
// Assumes: Plant model supplies VBUS and VCONN levels
// Notes:   Swap pulse shortened to 8 link clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, link_clock = 0, reset = 1;
  logic cc1_over_limit, cc2_over_limit, vbus_present_pin, vconn_overcurrent, over_temp;
  logic partner_rd_present, rd_presented, attached, debounce_done, receiver_detect_set;
  logic hard_reset_rx, command_strobe, measure_enable, force_discharge, auto_discharge;
  logic power_role, internal_bus_bleed_off, internal_cable_bleed_off, vconn_enable;
  logic flip_select, role_requests_rp, otsd_enable, quick_swap_write, load, vconn_at_safe0;
  logic presence_detect_on, quick_swap_busy, active_mode, phy_enable, bus_bleed_on;
  logic vconn_to_line1, vconn_to_line2, vconn_bleed_rd, present_rp, interrupt_n;
  logic quick_swap_pulse;
  logic [1:0] raw_line1_state, raw_line2_state, vendor_event, vendor_mask, fault_clear;
  logic [1:0] vendor_clear, line1_termination_state, line2_termination_state;
  logic [1:0] fault_flags, vendor_flags;
  logic [3:0] alert_mask, alert_clear, alert_flags;
  logic [7:0] command_code;
  logic [9:0] vbus_sample, sink_threshold, stop_level, vbus_voltage, load_level;
  int err_total = 0, num_checks = 0, i, pulse_len = 0;

  ppac_power_alert #(.QUICK_SWAP_CYCLES(8)) ppac_power_alert_inst (.*);
  ppac_plant ppac_plant_inst (.*);

  always #12.5 clock = ~clock;
  initial #3 forever #7.5 link_clock = ~link_clock;
  always @(posedge link_clock) if (quick_swap_pulse === 1'b1) pulse_len++;

  task look(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : look
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    {cc1_over_limit, cc2_over_limit, vbus_present_pin, vconn_overcurrent, over_temp,
     attached, debounce_done, receiver_detect_set, hard_reset_rx, command_strobe,
     measure_enable, force_discharge, auto_discharge, power_role, internal_bus_bleed_off,
     internal_cable_bleed_off, vconn_enable, flip_select, otsd_enable, quick_swap_write,
     load, rd_presented} = '0;
    {raw_line1_state, raw_line2_state, vendor_event, vendor_mask, fault_clear} = '0;
    {vendor_clear, alert_clear, command_code, sink_threshold, stop_level, load_level} = '0;
    {partner_rd_present, role_requests_rp, alert_mask} = {2'h3, 4'h7};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    look(2);
    chk({interrupt_n, vconn_to_line1, vconn_to_line2, bus_bleed_on}, 4'h8);
    command_strobe <= 1'b1;
    for (i = 1; i <= 7; i++) begin
      command_code <= 8'(i);
      look(1);
      chk(presence_detect_on, i == 6);
    end
    command_strobe <= 1'b0;
    {measure_enable, load, load_level} <= {2'h3, 10'h155};
    look(2);
    chk(vbus_voltage, 10'h155);
    {measure_enable, load_level} <= {1'b0, 10'h100};
    look(2);
    chk(vbus_voltage, 10'h155);
    {load, internal_bus_bleed_off, force_discharge} <= 3'h3;
    look(2);
    chk(bus_bleed_on, 1'b0);
    {internal_bus_bleed_off, force_discharge} <= 2'h0;
    look(2);
    force_discharge <= 1'b1;
    look(2);
    chk(bus_bleed_on, 1'b1);
    for (i = 0; i < 400 && bus_bleed_on; i++) look(1);
    chk(vbus_sample <= 10'h010 && vbus_sample > 10'h00c, 1'b1);
    {force_discharge, power_role, auto_discharge, load} <= 4'h7;
    {load_level, stop_level} <= {10'h100, 10'h080};
    look(2);
    {load, force_discharge} <= 2'h1;
    look(2);
    for (i = 0; i < 400 && bus_bleed_on; i++) look(1);
    chk(vbus_sample <= 10'h080 && vbus_sample > 10'h07c, 1'b1);
    {force_discharge, attached} <= 2'h1;
    look(2);
    chk({alert_flags, interrupt_n}, 5'h02);
    alert_clear <= 4'he;
    look(1);
    alert_clear <= 4'h0;
    look(1);
    chk(alert_flags, 4'h1);
    alert_clear <= 4'h1;
    look(1);
    {alert_clear, vendor_event} <= 6'h01;
    look(1);
    vendor_event <= 2'h0;
    look(1);
    chk({alert_flags, vendor_flags, interrupt_n}, 7'h03);
    {vendor_mask, alert_mask} <= 6'h1f;
    look(2);
    chk({alert_flags[3], interrupt_n}, 2'h2);
    vendor_clear <= 2'h1;
    look(1);
    // Alert vendor bit is sticky: clear it once the source flag is gone
    {vendor_clear, alert_clear} <= 6'h08;
    look(1);
    alert_clear <= 4'h0;
    look(1);
    chk(interrupt_n, 1'b1);
    {raw_line1_state, raw_line2_state, debounce_done, receiver_detect_set} <= 6'h27;
    look(2);
    chk({active_mode, phy_enable}, 2'h3);
    {rd_presented, cc1_over_limit, cc2_over_limit} <= 3'h7;
    look(4);
    chk({fault_flags, line1_termination_state, line2_termination_state}, 6'h20);
    {cc1_over_limit, cc2_over_limit} <= 2'h0;
    look(4);
    chk({line1_termination_state, line2_termination_state}, 4'h9);
    fault_clear <= 2'h2;
    look(1);
    {fault_clear, alert_clear} <= 6'h04;
    look(1);
    {alert_clear, flip_select, vconn_enable} <= 6'h03;
    look(1);
    chk({alert_flags, fault_flags, vconn_to_line1, vconn_to_line2}, 8'h01);
    // Supply stays valid (no overcurrent) until the switch has opened
    vconn_enable <= 1'b0;
    look(1);
    chk({vconn_to_line2, vconn_bleed_rd, present_rp}, 3'h2);
    for (i = 0; i < 20 && vconn_bleed_rd; i++) look(1);
    chk({i > 3, vconn_bleed_rd, present_rp}, 3'h5);
    vconn_enable <= 1'b1;
    look(1);
    vconn_overcurrent <= 1'b1;
    look(4);
    chk({vconn_to_line2, fault_flags[0]}, 2'h1);
    {vconn_overcurrent, vconn_enable, internal_cable_bleed_off} <= 3'h1;
    look(12);
    vconn_enable <= 1'b1;
    look(2);
    hard_reset_rx <= 1'b1;
    look(1);
    hard_reset_rx <= 1'b0;
    look(1);
    chk({vconn_to_line2, vconn_bleed_rd, bus_bleed_on}, 3'h0);
    quick_swap_write <= 1'b1;
    look(1);
    quick_swap_write <= 1'b0;
    chk(quick_swap_busy, 1'b1);
    for (i = 0; i < 50 && quick_swap_busy; i++) look(1);
    chk(pulse_len, 8);
    {auto_discharge, command_strobe, command_code} <= {2'h1, 8'h03};
    look(1);
    command_code <= 8'h04;
    look(1);
    command_code <= 8'h06;
    look(1);
    command_strobe <= 1'b0;
    chk(presence_detect_on, 1'b1);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
